// ==== design/l1c_policy_pkg.sv ====
// constants and types for the cache policy and maintenance block
// Functional notes
// - non-cacheable miss served directly, no fill
// - write-through write miss becomes through access
// - system register and exclusive accesses bypass cache
// - dual-bus same-line double miss goes through
// - both ways locked and valid: through
// - only pairs four to seven write-through
// - write-through hit updates both, pipe held
// - only pairs two to seven non-cacheable
// - each way lockable; locked valid never replaced
// - invalid line of locked way filled first
// - both locked and invalid: fill way zero
// - locked range lines never replaced once cached
// - cache starts disabled after reset
// - full maintenance stalls pipe and holds interrupts
// - full invalidation takes about 32 cycles
// - write-back one line at a time, dirty only
// - range start index and count computed, readable
// - index increments, count decrements per step
// - range index register writable for resume
// - range maintenance ignores locking
// - parity error raises interrupt to both sinks
// - range covers start inclusive to end exclusive
package l1c_policy_pkg;
  localparam int          NUM_PAIRS     = 8;
  localparam int          NUM_SETS      = 32;
  localparam int          LINE_BITS     = 6;
  localparam int          IDX_BITS      = 5;
  localparam logic [2:0]  WT_MIN_PAIR   = 3'h4;
  localparam logic [2:0]  NC_MIN_PAIR   = 3'h2;
  localparam int          FULL_INV_CYC  = 32;
  // register offsets, byte addresses of 32-bit words on the plain port
  localparam logic [7:0]  OFS_CFG       = 8'h00;
  localparam logic [7:0]  OFS_PROP      = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_INDEX     = 8'h0c;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_START0    = 8'h40;
  localparam logic [7:0]  OFS_END0      = 8'h60;
  // cache_control_config fields
  localparam int          CFG_EN        = 0;
  localparam int          CFG_LOCK0     = 1;
  localparam int          CFG_LOCK1     = 2;
  localparam int          CFG_INV       = 3;
  localparam int          CFG_WB        = 4;
  localparam int          CFG_RINV      = 5;
  localparam int          CFG_RWB       = 6;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  // range_property_config: 2 bits per pair
  localparam logic [1:0]  PROP_NONE     = 2'h0;
  localparam logic [1:0]  PROP_NC       = 2'h1;
  localparam logic [1:0]  PROP_WT       = 2'h2;
  localparam logic [1:0]  PROP_LOCK     = 2'h3;
  localparam logic [15:0] PROP_RESET    = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        sysreg;
    logic        exclusive;
    logic        dual_same_line;
    logic        other_miss;
    logic [31:0] addr;
  } req_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] way_valid;
    logic [1:0] way_dirty;
    logic [1:0] way_locked_range;
    logic       lru_way;
    logic       parity_err;
  } lookup_t;

  typedef struct packed {
    logic       through;
    logic       fill;
    logic       fill_way;
    logic       ext_write;
    logic       hold;
  } decision_t;

  typedef enum logic [2:0] {
    MS_IDLE  = 3'b000,
    MS_FULL  = 3'b001,
    MS_WB    = 3'b010,
    MS_RANGE = 3'b011,
    MS_RWB   = 3'b100
  } maint_t;
endpackage

// ==== design/l1c_policy_ctrl.sv ====
// policy decision, locking and maintenance sequencer of the level-one cache
`timescale 1ns/10ps
module l1c_policy_ctrl
(
  input  wire logic                       clk,          // core clock
  input  wire logic                       srst,         // sync reset, high
  input  wire logic [7:0]                 reg_addr,     // register address
  input  wire logic [31:0]                reg_wdata,    // write data
  input  wire logic                       reg_wr,       // write strobe
  input  wire logic                       reg_rd,       // read strobe
  output logic      [31:0]                reg_rdata,    // read data, next cycle
  input  wire l1c_policy_pkg::req_t       req,          // pipeline request
  input  wire l1c_policy_pkg::lookup_t    lookup,       // tag lookup result
  output l1c_policy_pkg::decision_t       decision,     // registered decision
  output logic                            cache_en,     // cache enabled
  input  wire logic                       ext_done,     // external write done
  output logic                            maint_valid,  // maintenance line op
  output logic      [4:0]                 maint_index,  // set being processed
  output logic                            maint_inv,    // invalidate this set
  output logic                            maint_wb,     // write back this set
  input  wire logic                       wb_done,      // line write back done
  output logic                            pipe_stall,   // stall core pipeline
  output logic                            irq_hold,     // hold interrupts
  output logic                            parity_irq,   // to interrupt latch
  output logic                            parity_sys    // to system controller
);
  logic [31:0]                  cfg_q;
  logic [15:0]                  prop_q;
  logic [31:0]                  start_q [l1c_policy_pkg::NUM_PAIRS];
  logic [31:0]                  end_q   [l1c_policy_pkg::NUM_PAIRS];
  logic [4:0]                   index_q;
  logic [5:0]                   count_q;
  logic [5:0]                   step_q;
  l1c_policy_pkg::maint_t       state_q;
  logic                         wt_hold_q;
  logic                         dirty_pend_q;

  // pair i holds addr, end exclusive
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] s,
                                    input logic [31:0] e);
    in_range = (a >= s) && (a < e);
  endfunction

  function automatic logic [1:0] prop_of(input logic [15:0] p, input int i);
    prop_of = p[2*i +: 2];
  endfunction
  logic nc_hit;
  logic wt_hit;
  always_comb
  begin
    nc_hit      = 1'b0;
    wt_hit      = 1'b0;
    for (int i = 0; i < l1c_policy_pkg::NUM_PAIRS; i++)
    begin
      if (in_range(req.addr, start_q[i], end_q[i]))
      begin
        if (i >= int'(l1c_policy_pkg::NC_MIN_PAIR)
            && prop_of(prop_q, i) == l1c_policy_pkg::PROP_NC)
          nc_hit = 1'b1;
        if (i >= int'(l1c_policy_pkg::WT_MIN_PAIR)
            && prop_of(prop_q, i) == l1c_policy_pkg::PROP_WT)
          wt_hit = 1'b1;
      end
    end
  end

  // per-way lockedness: config lock bits or range lock of the resident line
  logic [1:0] locked;
  assign locked = {cfg_q[l1c_policy_pkg::CFG_LOCK1], cfg_q[l1c_policy_pkg::CFG_LOCK0]}
                  | lookup.way_locked_range;
  logic      miss;
  logic      both_blocked;
  logic                        d_through;
  logic                        d_fill;
  logic                        d_way;
  always_comb
  begin
    miss         = req.valid && cache_en && !lookup.hit && !req.other_miss;
    both_blocked = &(locked & lookup.way_valid);
    d_through    = 1'b0;
    d_fill       = 1'b0;
    d_way        = lookup.lru_way;
    if (req.valid && (req.sysreg || req.exclusive))
      d_through = 1'b1;
    else if (miss)
    begin
      if (nc_hit)
        d_through = 1'b1;
      else if (req.write && wt_hit)
        d_through = 1'b1;
      else if (req.dual_same_line)
        d_through = 1'b1;
      else if (both_blocked)
        d_through = 1'b1;
      else
      begin
        d_fill = 1'b1;
        if (&locked && !lookup.way_valid[0] && !lookup.way_valid[1])
          d_way = 1'b0;
        else if (locked[0] && !lookup.way_valid[0])
          d_way = 1'b0;
        else if (locked[1] && !lookup.way_valid[1])
          d_way = 1'b1;
        else if (locked[lookup.lru_way] && lookup.way_valid[lookup.lru_way])
          d_way = ~lookup.lru_way;
      end
    end
  end
  // decision register; a through access requests no fill
  always_ff @(posedge clk)
  begin
    if (srst)
      decision <= '0;
    else
    begin
      decision.through   <= d_through;
      decision.fill      <= d_fill && !d_through;
      decision.fill_way  <= d_way;
      decision.ext_write <= req.valid && req.write && (d_through
                            || (wt_hit && cache_en && (lookup.hit || req.other_miss)));
      decision.hold      <= wt_hit && req.valid && req.write && cache_en
                            && (lookup.hit || req.other_miss);
    end
  end
  // write-through hit holds the pipe until external write completes
  always_ff @(posedge clk)
  begin
    if (srst)
      wt_hold_q <= 1'b0;
    else if (decision.hold)
      wt_hold_q <= 1'b1;
    else if (ext_done)
      wt_hold_q <= 1'b0;
  end
  // range start index and count from programmed pair 0
  logic [4:0] calc_index;
  logic [5:0] calc_count;
  logic [31:0] span;
  always_comb
  begin
    span       = end_q[0] - start_q[0];
    calc_index = start_q[0][l1c_policy_pkg::LINE_BITS +: l1c_policy_pkg::IDX_BITS];
    if (span[31:l1c_policy_pkg::LINE_BITS] >= 26'(l1c_policy_pkg::NUM_SETS))
      calc_count = 6'(l1c_policy_pkg::NUM_SETS);
    else
      calc_count = span[l1c_policy_pkg::LINE_BITS +: 6];
  end

  logic wr_cfg;
  logic wr_range;
  assign wr_cfg   = reg_wr && reg_addr == l1c_policy_pkg::OFS_CFG;
  assign wr_range = reg_wr && (reg_addr == l1c_policy_pkg::OFS_PROP
                    || reg_addr == l1c_policy_pkg::OFS_START0
                    || reg_addr == l1c_policy_pkg::OFS_END0);
  logic range_reload_q;

  // configuration and range registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_q  <= l1c_policy_pkg::CFG_RESET;
      prop_q <= l1c_policy_pkg::PROP_RESET;
      for (int i = 0; i < l1c_policy_pkg::NUM_PAIRS; i++)
      begin
        start_q[i] <= '0;
        end_q[i]   <= '0;
      end
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= reg_wdata;
      else if (state_q != l1c_policy_pkg::MS_IDLE)
      begin
        cfg_q[l1c_policy_pkg::CFG_INV]  <= 1'b0;
        cfg_q[l1c_policy_pkg::CFG_WB]   <= 1'b0;
        cfg_q[l1c_policy_pkg::CFG_RINV] <= 1'b0;
        cfg_q[l1c_policy_pkg::CFG_RWB]  <= 1'b0;
      end
      if (reg_wr && reg_addr == l1c_policy_pkg::OFS_PROP)
        prop_q <= reg_wdata[15:0];
      for (int i = 0; i < l1c_policy_pkg::NUM_PAIRS; i++)
      begin
        if (reg_wr && reg_addr == l1c_policy_pkg::OFS_START0 + 8'(4 * i))
          start_q[i] <= reg_wdata;
        if (reg_wr && reg_addr == l1c_policy_pkg::OFS_END0 + 8'(4 * i))
          end_q[i] <= reg_wdata;
      end
    end
  end
  assign cache_en = cfg_q[l1c_policy_pkg::CFG_EN];

  always_ff @(posedge clk)
  begin
    if (srst)
      range_reload_q <= 1'b0;
    else
      range_reload_q <= wr_range;
  end

  // maintenance sequencer
  logic step_fire;
  assign step_fire = (state_q == l1c_policy_pkg::MS_FULL)
                     || (state_q == l1c_policy_pkg::MS_RANGE && count_q != '0)
                     || ((state_q == l1c_policy_pkg::MS_WB
                          || state_q == l1c_policy_pkg::MS_RWB) && wb_done);

  always_ff @(posedge clk)
  begin
    if (srst)
      state_q <= l1c_policy_pkg::MS_IDLE;
    else
    begin
      case (state_q)
        l1c_policy_pkg::MS_IDLE:
          if (cfg_q[l1c_policy_pkg::CFG_INV] && cache_en)
            state_q <= cfg_q[l1c_policy_pkg::CFG_WB] ? l1c_policy_pkg::MS_WB
                       : l1c_policy_pkg::MS_FULL;
          else if (cfg_q[l1c_policy_pkg::CFG_RINV] && cache_en)
            state_q <= cfg_q[l1c_policy_pkg::CFG_RWB] ? l1c_policy_pkg::MS_RWB
                       : l1c_policy_pkg::MS_RANGE;
        l1c_policy_pkg::MS_FULL,
        l1c_policy_pkg::MS_WB:
          if (step_fire && step_q == 6'(l1c_policy_pkg::FULL_INV_CYC - 1))
            state_q <= l1c_policy_pkg::MS_IDLE;
        l1c_policy_pkg::MS_RANGE,
        l1c_policy_pkg::MS_RWB:
          if (count_q == '0 || (step_fire && count_q == 6'h01))
            state_q <= l1c_policy_pkg::MS_IDLE;
        default:
          state_q <= l1c_policy_pkg::MS_IDLE;
      endcase
    end
  end
  // full-cache step counter, one set per cycle or per write back
  always_ff @(posedge clk)
  begin
    if (srst || state_q == l1c_policy_pkg::MS_IDLE)
      step_q <= '0;
    else if (step_fire)
      step_q <= step_q + 6'h01;
  end

  // running index and count registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      index_q <= '0;
      count_q <= '0;
    end
    else if (reg_wr && reg_addr == l1c_policy_pkg::OFS_INDEX)
      index_q <= reg_wdata[4:0];
    else if (range_reload_q)
    begin
      index_q <= calc_index;
      count_q <= calc_count;
    end
    else if (step_fire && (state_q == l1c_policy_pkg::MS_RANGE
                           || state_q == l1c_policy_pkg::MS_RWB))
    begin
      index_q <= index_q + 5'h01;
      count_q <= count_q - 6'h01;
    end
  end

  // one line at a time; write back only dirty lines, locking ignored
  always_ff @(posedge clk)
  begin
    if (srst)
      dirty_pend_q <= 1'b0;
    else
      dirty_pend_q <= |lookup.way_dirty;
  end

  logic wb_state;
  assign wb_state    = state_q == l1c_policy_pkg::MS_WB || state_q == l1c_policy_pkg::MS_RWB;
  assign maint_valid = state_q != l1c_policy_pkg::MS_IDLE;
  assign maint_index = (state_q == l1c_policy_pkg::MS_FULL || state_q == l1c_policy_pkg::MS_WB)
                       ? step_q[4:0] : index_q;
  assign maint_inv   = maint_valid;
  assign maint_wb    = wb_state && dirty_pend_q;

  assign pipe_stall = maint_valid || wt_hold_q || decision.hold;
  assign irq_hold   = maint_valid;

  // parity error pulse to both sinks
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      parity_irq <= 1'b0;
      parity_sys <= 1'b0;
    end
    else
    begin
      parity_irq <= lookup.parity_err;
      parity_sys <= lookup.parity_err;
    end
  end

  // read port
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        l1c_policy_pkg::OFS_CFG:    reg_rdata <= cfg_q;
        l1c_policy_pkg::OFS_PROP:   reg_rdata <= {16'h0000, prop_q};
        l1c_policy_pkg::OFS_STATUS: reg_rdata <= {28'h0000000, wt_hold_q, state_q};
        l1c_policy_pkg::OFS_INDEX:  reg_rdata <= {27'h0000000, index_q};
        l1c_policy_pkg::OFS_COUNT:  reg_rdata <= {26'h0000000, count_q};
        default:
        begin
          reg_rdata <= '0;
          for (int i = 0; i < l1c_policy_pkg::NUM_PAIRS; i++)
          begin
            if (reg_addr == l1c_policy_pkg::OFS_START0 + 8'(4 * i))
              reg_rdata <= start_q[i];
            if (reg_addr == l1c_policy_pkg::OFS_END0 + 8'(4 * i))
              reg_rdata <= end_q[i];
          end
        end
      endcase
    end
    else
      reg_rdata <= '0;
  end

  a_disabled_reset: assert property (@(posedge clk) $fell(srst) |-> !cache_en)
    else $error("cache enabled right after reset");
  a_nc_through: assert property (@(posedge clk) disable iff (srst)
    (miss && nc_hit && !req.sysreg && !req.exclusive) |=> decision.through && !decision.fill)
    else $error("non-cacheable miss filled");
  a_wt_miss: assert property (@(posedge clk) disable iff (srst)
    (miss && req.write && wt_hit && !nc_hit) |=> decision.through && !decision.fill)
    else $error("write-through write miss filled");
  a_sys_bypass: assert property (@(posedge clk) disable iff (srst)
    (req.valid && (req.sysreg || req.exclusive)) |=> decision.through)
    else $error("system or exclusive access not through");
  a_both_locked: assert property (@(posedge clk) disable iff (srst)
    (miss && both_blocked) |=> !decision.fill)
    else $error("fill with both ways locked valid");
  a_fill_way0: assert property (@(posedge clk) disable iff (srst)
    (d_fill && !d_through && &locked && lookup.way_valid == 2'b00) |=> !decision.fill_way)
    else $error("fill not to way zero");
  a_wt_hold: assert property (@(posedge clk) disable iff (srst)
    decision.hold |=> wt_hold_q && pipe_stall)
    else $error("pipe released before external write");
  a_maint_stall: assert property (@(posedge clk) disable iff (srst)
    maint_valid |-> pipe_stall && irq_hold)
    else $error("maintenance without stall");
  a_full_len: assert property (@(posedge clk) disable iff (srst)
    $rose(state_q == l1c_policy_pkg::MS_FULL) |-> ##[31:33] state_q == l1c_policy_pkg::MS_IDLE)
    else $error("full invalidation length wrong");
  a_run_count: assert property (@(posedge clk) disable iff (srst)
    (step_fire && state_q == l1c_policy_pkg::MS_RANGE && !reg_wr)
    |=> count_q == $past(count_q) - 6'h01 && index_q == $past(index_q) + 5'h01)
    else $error("running registers did not step");
  a_parity_out: assert property (@(posedge clk) disable iff (srst)
    lookup.parity_err |=> parity_irq && parity_sys)
    else $error("parity error not raised");
endmodule

// ==== sim/ext_mem_model.sv ====
// behavioural external memory: answers through writes and line write-backs
`timescale 1ns/10ps
module ext_mem_model
(
  input  wire logic                      clk,       // core clock
  input  wire logic                      srst,      // sync reset
  input  wire l1c_policy_pkg::decision_t decision,  // policy decision
  input  wire logic                      maint_wb,  // line write-back asked
  input  wire logic [3:0]                dly,       // answer delay, cycles
  output logic                           ext_done,  // through write complete
  output logic                           wb_done    // write-back complete
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic [3:0] wcnt_q;

  // one outstanding through write, answered after dly cycles
  always_ff @(posedge clk)
  begin
    ext_done <= 1'b0;
    if (srst)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
    end
    else if (decision.ext_write)
    begin
      busy_q <= 1'b1;
      cnt_q  <= 4'h0;
    end
    else if (busy_q && cnt_q == dly)
    begin
      busy_q   <= 1'b0;
      ext_done <= 1'b1;
    end
    else if (busy_q)
      cnt_q <= cnt_q + 4'h1;
  end

  // lines are taken one at a time while a write-back is asked
  always_ff @(posedge clk)
  begin
    wb_done <= 1'b0;
    if (srst || !maint_wb || wb_done)
      wcnt_q <= 4'h0;
    else if (wcnt_q == dly)
      wb_done <= 1'b1;
    else
      wcnt_q <= wcnt_q + 4'h1;
  end
endmodule

// ==== sim/l1c_policy_ctrl_tb.sv ====
// self-checking bench for the cache policy and maintenance block
`timescale 1ns/10ps
module l1c_policy_ctrl_tb;
  typedef struct packed {
    logic [1:0]              lock;
    l1c_policy_pkg::req_t    r;
    l1c_policy_pkg::lookup_t l;
    logic [2:0]              exp;
  } row_t;

  logic                      clk;
  logic                      srst;
  logic [7:0]                reg_addr;
  logic [31:0]               reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [31:0]               reg_rdata;
  l1c_policy_pkg::req_t      req;
  l1c_policy_pkg::lookup_t   lookup;
  l1c_policy_pkg::decision_t decision;
  logic                      cache_en;
  logic                      ext_done;
  logic                      maint_valid;
  logic [4:0]                maint_index;
  logic                      maint_inv;
  logic                      maint_wb;
  logic                      wb_done;
  logic                      pipe_stall;
  logic                      irq_hold;
  logic                      parity_irq;
  logic                      parity_sys;
  logic [3:0]                dly;
  int                        error_cnt;
  int                        checked;
  int                        last_cyc;
  logic [4:0]                first_idx;
  row_t                      rows[18];
  row_t                      t;

  l1c_policy_ctrl u_l1c_policy_ctrl (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req(req), .lookup(lookup), .decision(decision), .cache_en(cache_en),
    .ext_done(ext_done), .maint_valid(maint_valid), .maint_index(maint_index),
    .maint_inv(maint_inv), .maint_wb(maint_wb), .wb_done(wb_done),
    .pipe_stall(pipe_stall), .irq_hold(irq_hold), .parity_irq(parity_irq),
    .parity_sys(parity_sys));

  ext_mem_model u_ext_mem_model (.clk(clk), .srst(srst), .decision(decision),
    .maint_wb(maint_wb), .dly(dly), .ext_done(ext_done), .wb_done(wb_done));

  // kind = {write, sysreg, exclusive, dual}; lu = {hit, valid, locked_range, lru}
  function automatic row_t mk(logic [1:0] lk, logic [3:0] kind, logic [31:0] a,
                              logic [5:0] lu, logic [2:0] e);
    mk.lock = lk;
    mk.r    = '{1'b1, kind[3], kind[2], kind[1], kind[0], 1'b0, a};
    mk.l    = '{lu[5], lu[4:3], 2'h3, lu[2:1], lu[0], 1'b0};
    mk.exp  = e;
  endfunction

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(nm, reg_rdata, e);
  endtask

  task automatic issue(row_t x);
    @(posedge clk);
    req    <= x.r;
    lookup <= x.l;
    @(posedge clk);
    req    <= '0;
    lookup <= '0;
    #1;
  endtask

  task automatic set_range(int i, logic [31:0] s, logic [31:0] e);
    wr(l1c_policy_pkg::OFS_START0 + 8'(4 * i), s);
    wr(l1c_policy_pkg::OFS_END0 + 8'(4 * i), e);
  endtask

  task automatic run_maint(logic [31:0] cfg, int steps);
    int         n = 0;
    int         wbn = 0;
    int         bad = 0;
    logic [4:0] last = '0;
    last_cyc = 0;
    wr(l1c_policy_pkg::OFS_CFG, cfg);
    repeat (800)
    begin
      @(posedge clk);
      #1;
      if (maint_valid === 1'b1)
      begin
        last_cyc++;
        if (n == 0 || maint_index !== last)
          n++;
        if (n == 1)
          first_idx = maint_index;
        last = maint_index;
      end
      if (wb_done === 1'b1)
        wbn++;
      if ({pipe_stall, irq_hold, maint_inv} !== {3{maint_valid}})
        bad++;
    end
    check("maint_steps", n, steps);
    check("stall_cycles_bad", bad, 0);
    if (cfg[4] | cfg[6])
      check("wb_lines", wbn, steps);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #500_000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    rows[0]  = mk(2'h0, 4'h0, 32'h0000_1000, 6'b011001, 3'b011);
    rows[1]  = mk(2'h0, 4'h0, 32'h1000_0040, 6'b011001, 3'b100);
    rows[2]  = mk(2'h0, 4'h0, 32'h1000_0000, 6'b011001, 3'b100);
    rows[3]  = mk(2'h0, 4'h0, 32'h1000_1000, 6'b011001, 3'b011);
    rows[4]  = mk(2'h0, 4'h0, 32'h3000_0000, 6'b011001, 3'b011);
    rows[5]  = mk(2'h0, 4'h8, 32'h2000_0000, 6'b011001, 3'b100);
    rows[6]  = mk(2'h0, 4'h0, 32'h2000_0000, 6'b011001, 3'b011);
    rows[7]  = mk(2'h0, 4'h8, 32'h4000_0000, 6'b011001, 3'b011);
    rows[8]  = mk(2'h0, 4'h4, 32'h0000_1000, 6'b011001, 3'b100);
    rows[9]  = mk(2'h0, 4'h2, 32'h0000_1000, 6'b011001, 3'b100);
    rows[10] = mk(2'h0, 4'h1, 32'h0000_1000, 6'b011001, 3'b100);
    rows[11] = mk(2'h3, 4'h0, 32'h0000_1000, 6'b011001, 3'b100);
    rows[12] = mk(2'h1, 4'h0, 32'h0000_1000, 6'b010001, 3'b010);
    rows[13] = mk(2'h3, 4'h0, 32'h0000_1000, 6'b000001, 3'b010);
    rows[14] = mk(2'h1, 4'h0, 32'h0000_1000, 6'b011000, 3'b011);
    rows[15] = mk(2'h0, 4'h0, 32'h0000_1000, 6'b011110, 3'b100);
    rows[16] = mk(2'h0, 4'h0, 32'h0000_1000, 6'b011010, 3'b011);
    rows[17] = mk(2'h0, 4'h0, 32'h0000_1000, 6'b111001, 3'b000);
    {srst, reg_addr, reg_wdata, reg_wr, reg_rd, req, lookup, dly} = '0;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rchk("cfg_reset", l1c_policy_pkg::OFS_CFG, 32'h0);
    rchk("prop_reset", l1c_policy_pkg::OFS_PROP, 32'h0);
    check("cache_en", cache_en, 32'h0);
    issue(rows[0]);
    check("fill_disabled", decision.fill, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rchk("unmapped", 8'h20, 32'h0);
    $display("test reset done");
    wr(l1c_policy_pkg::OFS_PROP, 32'h0000_0294);
    set_range(1, 32'h3000_0000, 32'h3000_1000);
    set_range(2, 32'h1000_0000, 32'h1000_1000);
    set_range(3, 32'h4000_0000, 32'h4000_1000);
    set_range(4, 32'h2000_0000, 32'h2000_1000);
    for (int i = 0; i < 18; i++)
    begin
      wr(l1c_policy_pkg::OFS_CFG, {29'h0, rows[i].lock, 1'b1});
      issue(rows[i]);
      check("through_fill", {decision.through, decision.fill}, rows[i].exp[2:1]);
      if (rows[i].exp[1])
        check("fill_way", decision.fill_way, rows[i].exp[0]);
    end
    $display("test decision table done");
    dly = 4'h3;
    t = mk(2'h0, 4'h8, 32'h2000_0000, 6'b111001, 3'b000);
    issue(t);
    check("wt_hit", {decision.ext_write, decision.hold, decision.fill}, 3'b110);
    check("wt_stall", pipe_stall, 32'h1);
    rchk("status_hold", l1c_policy_pkg::OFS_STATUS, 32'h8);
    last_cyc = 0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (ext_done === 1'b1)
        last_cyc = 1;
    end
    check("wt_done", last_cyc, 1);
    check("wt_release", pipe_stall, 32'h0);
    t.l.parity_err = 1'b1;
    issue(t);
    check("parity", {parity_irq, parity_sys}, 2'b11);
    @(posedge clk);
    #1;
    check("parity_end", {parity_irq, parity_sys}, 2'b00);
    $display("test through and parity done");
    @(posedge clk);
    lookup <= '{1'b0, 2'h3, 2'h3, 2'h0, 1'b0, 1'b0};
    set_range(0, 32'h0000_0080, 32'h0000_0200);
    rchk("index", l1c_policy_pkg::OFS_INDEX, 32'h2);
    rchk("count", l1c_policy_pkg::OFS_COUNT, 32'h6);
    wr(l1c_policy_pkg::OFS_INDEX, 32'h4);
    rchk("index_wr", l1c_policy_pkg::OFS_INDEX, 32'h4);
    wr(l1c_policy_pkg::OFS_END0, 32'h0000_0200);
    run_maint(32'h09, l1c_policy_pkg::NUM_SETS);
    check("inv_cycles", last_cyc, l1c_policy_pkg::FULL_INV_CYC);
    run_maint(32'h19, l1c_policy_pkg::NUM_SETS);
    run_maint(32'h27, 6);
    check("first_idx", first_idx, 32'h2);
    rchk("index_end", l1c_policy_pkg::OFS_INDEX, 32'h8);
    rchk("count_end", l1c_policy_pkg::OFS_COUNT, 32'h0);
    wr(l1c_policy_pkg::OFS_END0, 32'h0000_0200);
    run_maint(32'h61, 6);
    $display("test maintenance done");
    finish_test();
  end
endmodule
